// [design/cr_move_pkg.sv]
// Purpose: Shared constants for the condition/mask move execution unit.
// Assumes: Instruction bits are numbered from the most significant end (bit 0 is the MSB).
// Notes: All opcode, field and reset figures used by the unit live here.
package cr_move_pkg;
   // Primary and extended opcodes.
   localparam logic [5:0] OP_FIXED = 6'h1F;
   localparam logic [5:0] OP_BRANCH = 6'h13;
   localparam logic [5:0] OP_FLOAT = 6'h3F;
   localparam logic [9:0] XO_MASK_INSERT = 10'h21D;
   localparam logic [9:0] XO_FIELD_COPY = 10'h000;
   localparam logic [9:0] XO_FS_TO_COND = 10'h040;
   localparam logic [9:0] XO_EXC_TO_COND = 10'h200;
   localparam logic [9:0] XO_COND_TO_GPR = 10'h013;
   localparam logic [9:0] XO_FS_TO_FPR = 10'h247;
   // Register port offsets.
   localparam logic [1:0] ADDR_COND = 2'h0;
   localparam logic [1:0] ADDR_FIXED_EXC = 2'h1;
   localparam logic [1:0] ADDR_FLOAT_STATUS = 2'h2;
   localparam logic [1:0] ADDR_STATUS = 2'h3;
   // Reset values.
   localparam logic [31:0] COND_RESET = 32'h0000_0000;
   localparam logic [31:0] FIXED_EXC_RESET = 32'h0000_0000;
   localparam logic [31:0] FLOAT_STATUS_RESET = 32'h0000_0000;
   // Fill used for the undefined upper half of a floating status move.
   localparam logic [31:0] FPR_UPPER_FILL = 32'hFFFF_FFFF;
   // Reserved positions of the floating status register (one marks reserved).
   localparam logic [31:0] FS_RESERVED_MASK = 32'h0000_0800;
   // Condition field numbers.
   localparam logic [2:0] FIELD_ZERO = 3'h0;
   localparam logic [2:0] FIELD_ONE = 3'h1;
   // Exception bits cleared per floating status field when copied out.
   localparam logic [2:0] FS_FIELD_0 = 3'h0;
   localparam logic [2:0] FS_FIELD_1 = 3'h1;
   localparam logic [2:0] FS_FIELD_2 = 3'h2;
   localparam logic [2:0] FS_FIELD_3 = 3'h3;
   localparam logic [3:0] FS_CLR_0 = 4'h9;
   localparam logic [3:0] FS_CLR_1 = 4'hF;
   localparam logic [3:0] FS_CLR_2 = 4'hF;
   localparam logic [3:0] FS_CLR_3 = 4'h8;
   localparam logic [3:0] NIBBLE_ZERO = 4'h0;
   localparam logic [3:0] NIBBLE_ONES = 4'hF;
   localparam logic [27:0] NIBBLE_PAD = 28'h000_0000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [4:0] IDX_ZERO = 5'h00;
endpackage

// [design/cr_mask_move_unit.sv]
// Purpose: Executes masked insert and condition/status/exception register moves.
// Assumes: The core presents one decoded-or-not instruction word per valid cycle,
//          with operand values already read from the register files.
// Notes: Results appear one cycle after the instruction; register port reads
//        return data in the cycle after the read strobe.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

// Operation
// - Masked insert takes source bits where mask is one, keeps target elsewhere.
// - Masked insert decodes primary 31, extended 541; bit 31 is record flag.
// - Masked insert leaves exception register; record flag updates field zero.
// - Field copy, primary 19, copies source field bits 11-13 to field 6-8.
// - Field copy changes no other field, nor field zero unless it is the target, nor exception register.
// - Status to condition copy, 63/64, copies selected status field to condition.
// - Reserved status positions read as zero in that copy.
// - That copy clears the exception bits belonging to the source field.
// - Status field selector names one of eight fields, zero to seven.
// - Exception to condition copy moves exception bits 0-3 then clears them.
// - Condition to general move copies whole condition register, exception untouched.
// - Status to float move writes status into low word; upper word undefined.
// - Status to float move keeps status; record flag updates condition field one.
module cr_mask_move_unit
   import cr_move_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic instr_valid_in,
   input wire logic [31:0] instr_in,
   input wire logic [31:0] source_gpr_in,
   input wire logic [31:0] insert_target_gpr_in,
   input wire logic [31:0] mask_gpr_in,
   input wire logic [1:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   output logic gpr_we_out,
   output logic [4:0] gpr_idx_out,
   output logic [31:0] gpr_data_out,
   output logic fpr_we_out,
   output logic [4:0] fpr_idx_out,
   output logic [63:0] fpr_data_out,
   output logic illegal_out,
   output logic [31:0] cond_reg_out,
   output logic [31:0] fixed_exception_reg_out,
   output logic [31:0] float_status_ctrl_reg_out
);

   typedef struct packed {
      logic [31:0] cond_reg;
      logic [31:0] fixed_exception_reg;
      logic [31:0] float_status_ctrl_reg;
      logic [31:0] rdata;
      logic gpr_we;
      logic [4:0] gpr_idx;
      logic [31:0] gpr_data;
      logic fpr_we;
      logic [4:0] fpr_idx;
      logic [63:0] fpr_data;
      logic illegal;
   } state_t;

   state_t q;
   state_t next_q;

   // Fields are numbered from the MSB, so a left shift brings field n to the top.
   // field layout
   function automatic logic [3:0] get_field(input logic [31:0] r, input logic [2:0] n);
      logic [31:0] s;
      s = r << {n, 2'b00};
      return s[31:28];
   endfunction

   function automatic logic [31:0] put_field(input logic [31:0] r, input logic [2:0] n,
                                             input logic [3:0] v);
      logic [31:0] m;
      logic [31:0] d;
      m = {NIBBLE_ONES, NIBBLE_PAD} >> {n, 2'b00};
      d = {v, NIBBLE_PAD} >> {n, 2'b00};
      return (r & ~m) | d;
   endfunction

   // Less, greater, equal against zero, then the summary overflow copy.
   function automatic logic [3:0] cr0_of(input logic [31:0] res, input logic so);
      logic is_neg;
      logic is_pos;
      logic is_zero;
      is_neg = res[31];
      is_zero = (res == WORD_ZERO);
      is_pos = !is_neg && !is_zero;
      return {is_neg, is_pos, is_zero, so};
   endfunction

   // Exception bits that a status-field copy consumes; upper fields hold none.
   // consumed bits
   function automatic logic [3:0] fs_clear_bits(input logic [2:0] sel);
      logic [3:0] c;
      c = NIBBLE_ZERO;
      if (sel == FS_FIELD_0) begin
         c = FS_CLR_0;
      end else if (sel == FS_FIELD_1) begin
         c = FS_CLR_1;
      end else if (sel == FS_FIELD_2) begin
         c = FS_CLR_2;
      end else if (sel == FS_FIELD_3) begin
         c = FS_CLR_3;
      end
      return c;
   endfunction

   // Instruction fields, MSB-numbered positions mapped onto vector indices.
   logic [5:0] opcode;
   logic [9:0] xo;
   logic record_flag;
   logic [4:0] dest_gpr;
   logic [4:0] dest_fpr;
   logic [4:0] insert_target_gpr;
   logic [2:0] dest_cond_field;
   logic [2:0] source_field_sel;
   assign opcode = instr_in[31:26];
   assign xo = instr_in[10:1];
   assign record_flag = instr_in[0];
   assign dest_gpr = instr_in[25:21];
   assign dest_fpr = instr_in[25:21];
   assign insert_target_gpr = instr_in[20:16];
   assign dest_cond_field = instr_in[25:23];
   assign source_field_sel = instr_in[20:18];

   // Decode one-hot operation selects.
   // operation decode
   logic is_insert;
   logic is_field_copy;
   logic is_fs_to_cond;
   logic is_exc_to_cond;
   logic is_cond_to_gpr;
   logic is_fs_to_fpr;
   assign is_insert = instr_valid_in && opcode == OP_FIXED && xo == XO_MASK_INSERT;
   assign is_field_copy = instr_valid_in && opcode == OP_BRANCH && xo == XO_FIELD_COPY;
   assign is_fs_to_cond = instr_valid_in && opcode == OP_FLOAT && xo == XO_FS_TO_COND;
   assign is_exc_to_cond = instr_valid_in && opcode == OP_FIXED && xo == XO_EXC_TO_COND;
   assign is_cond_to_gpr = instr_valid_in && opcode == OP_FIXED && xo == XO_COND_TO_GPR;
   assign is_fs_to_fpr = instr_valid_in && opcode == OP_FLOAT && xo == XO_FS_TO_FPR;

   // Next-state logic. Instructions read the registered values, so a software
   // write in the same cycle lands first and the instruction's bits overwrite it.
   always_comb begin
      logic [31:0] insert_res;
      logic [3:0] fs_field;
      insert_res = WORD_ZERO;
      fs_field = NIBBLE_ZERO;
      next_q = q;
      next_q.gpr_we = 1'b0;
      next_q.fpr_we = 1'b0;
      next_q.illegal = 1'b0;
      next_q.rdata = WORD_ZERO;
      // Software register port.
      if (reg_wr_in) begin
         unique case (reg_addr_in)
            ADDR_COND: next_q.cond_reg = reg_wdata_in;
            ADDR_FIXED_EXC: next_q.fixed_exception_reg = reg_wdata_in;
            ADDR_FLOAT_STATUS: next_q.float_status_ctrl_reg = reg_wdata_in;
            ADDR_STATUS: next_q.cond_reg = q.cond_reg;
         endcase
      end
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            ADDR_COND: next_q.rdata = q.cond_reg;
            ADDR_FIXED_EXC: next_q.rdata = q.fixed_exception_reg;
            ADDR_FLOAT_STATUS: next_q.rdata = q.float_status_ctrl_reg;
            ADDR_STATUS: next_q.rdata = {WORD_ZERO[31:1], q.illegal};
         endcase
      end
      if (is_insert) begin
         insert_res = (source_gpr_in & mask_gpr_in) | (insert_target_gpr_in & ~mask_gpr_in);
         next_q.gpr_we = 1'b1;
         next_q.gpr_idx = insert_target_gpr;
         next_q.gpr_data = insert_res;
         if (record_flag) begin
            next_q.cond_reg = put_field(next_q.cond_reg, FIELD_ZERO,
                                        cr0_of(insert_res, q.fixed_exception_reg[31]));
         end
      end else if (is_field_copy) begin
         next_q.cond_reg = put_field(next_q.cond_reg, dest_cond_field,
                                     get_field(q.cond_reg, source_field_sel));
      end else if (is_fs_to_cond) begin
         fs_field = get_field(q.float_status_ctrl_reg, source_field_sel) &
                    ~get_field(FS_RESERVED_MASK, source_field_sel);
         next_q.cond_reg = put_field(next_q.cond_reg, dest_cond_field, fs_field);
         next_q.float_status_ctrl_reg = put_field(next_q.float_status_ctrl_reg,
            source_field_sel,
            get_field(next_q.float_status_ctrl_reg, source_field_sel) &
            ~fs_clear_bits(source_field_sel));
      end else if (is_exc_to_cond) begin
         next_q.cond_reg = put_field(next_q.cond_reg, dest_cond_field,
                                     get_field(q.fixed_exception_reg, FIELD_ZERO));
         next_q.fixed_exception_reg = put_field(next_q.fixed_exception_reg, FIELD_ZERO,
                                                NIBBLE_ZERO);
      end else if (is_cond_to_gpr) begin
         next_q.gpr_we = 1'b1;
         next_q.gpr_idx = dest_gpr;
         next_q.gpr_data = q.cond_reg;
      end else if (is_fs_to_fpr) begin
         next_q.fpr_we = 1'b1;
         next_q.fpr_idx = dest_fpr;
         next_q.fpr_data = {FPR_UPPER_FILL, q.float_status_ctrl_reg};
         if (record_flag) begin
            next_q.cond_reg = put_field(next_q.cond_reg, FIELD_ONE,
                                        get_field(q.float_status_ctrl_reg, FIELD_ZERO));
         end
      end else if (instr_valid_in) begin
         // Unknown words are flagged, never executed; the core decides the trap.
         next_q.illegal = 1'b1;
      end
   end

   // State register.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q.cond_reg <= COND_RESET;
         q.fixed_exception_reg <= FIXED_EXC_RESET;
         q.float_status_ctrl_reg <= FLOAT_STATUS_RESET;
         q.rdata <= WORD_ZERO;
         q.gpr_we <= 1'b0;
         q.gpr_idx <= IDX_ZERO;
         q.gpr_data <= WORD_ZERO;
         q.fpr_we <= 1'b0;
         q.fpr_idx <= IDX_ZERO;
         q.fpr_data <= {WORD_ZERO, WORD_ZERO};
         q.illegal <= 1'b0;
      end else begin
         q <= next_q;
      end
   end

   // Outputs come straight from the state flops.
   assign reg_rdata_out = q.rdata;
   assign gpr_we_out = q.gpr_we;
   assign gpr_idx_out = q.gpr_idx;
   assign gpr_data_out = q.gpr_data;
   assign fpr_we_out = q.fpr_we;
   assign fpr_idx_out = q.fpr_idx;
   assign fpr_data_out = q.fpr_data;
   assign illegal_out = q.illegal;
   assign cond_reg_out = q.cond_reg;
   assign fixed_exception_reg_out = q.fixed_exception_reg;
   assign float_status_ctrl_reg_out = q.float_status_ctrl_reg;

   // Checks on register updates below exclude cycles with a software write, which may overlap any field.
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);

   insert_result_a: assert property (
      is_insert && !reg_wr_in |=> gpr_we_out && gpr_data_out ==
         (($past(source_gpr_in) & $past(mask_gpr_in)) |
          ($past(insert_target_gpr_in) & ~$past(mask_gpr_in))))
      else $error("Masked insert result is wrong.");

   insert_decode_a: assert property (
      is_insert |=> gpr_idx_out == $past(instr_in[20:16]) && !fpr_we_out && !illegal_out)
      else $error("Masked insert decode or target index is wrong.");

   insert_record_a: assert property (
      is_insert && !reg_wr_in |=> $stable(fixed_exception_reg_out) &&
         (cond_reg_out[31:28] == ($past(record_flag) ?
            cr0_of(gpr_data_out, fixed_exception_reg_out[31]) : $past(cond_reg_out[31:28]))))
      else $error("Masked insert field zero or exception register is wrong.");

   field_copy_a: assert property (
      is_field_copy && !reg_wr_in |=> get_field(cond_reg_out, $past(dest_cond_field)) ==
         get_field($past(cond_reg_out), $past(source_field_sel)))
      else $error("Condition field copy moved the wrong value.");

   field_keep_a: assert property (
      is_field_copy && !reg_wr_in |=> $stable(fixed_exception_reg_out) &&
         put_field(cond_reg_out, $past(dest_cond_field), NIBBLE_ZERO) ==
         put_field($past(cond_reg_out), $past(dest_cond_field), NIBBLE_ZERO))
      else $error("Condition field copy disturbed other state.");

   fs_copy_a: assert property (
      is_fs_to_cond && !reg_wr_in |=> get_field(cond_reg_out, $past(dest_cond_field)) ==
         (get_field($past(float_status_ctrl_reg_out), $past(source_field_sel)) &
          ~get_field(FS_RESERVED_MASK, $past(source_field_sel))))
      else $error("Status to condition copy moved the wrong value.");

   fs_reserved_a: assert property (
      is_fs_to_cond && !reg_wr_in |=>
         (get_field(cond_reg_out, $past(dest_cond_field)) &
          get_field(FS_RESERVED_MASK, $past(source_field_sel))) == NIBBLE_ZERO)
      else $error("Reserved status position reached the condition field.");

   fs_clear_a: assert property (
      is_fs_to_cond && !reg_wr_in |=>
         float_status_ctrl_reg_out == put_field($past(float_status_ctrl_reg_out),
            $past(source_field_sel),
            get_field($past(float_status_ctrl_reg_out), $past(source_field_sel)) &
            ~fs_clear_bits($past(source_field_sel))))
      else $error("Status exception bits were not cleared correctly.");

   exc_copy_a: assert property (
      is_exc_to_cond && !reg_wr_in |=> fixed_exception_reg_out[31:28] == NIBBLE_ZERO &&
         get_field(cond_reg_out, $past(dest_cond_field)) ==
         $past(fixed_exception_reg_out[31:28]) ##1 !is_exc_to_cond || reg_wr_in ||
         get_field(next_q.cond_reg, dest_cond_field) == NIBBLE_ZERO)
      else $error("Exception to condition copy or clear is wrong.");

   cond_gpr_a: assert property (
      is_cond_to_gpr && !reg_wr_in |=> gpr_we_out && gpr_data_out == $past(cond_reg_out) &&
         $stable(fixed_exception_reg_out) && gpr_idx_out == $past(dest_gpr))
      else $error("Condition to general move is wrong.");

   fs_fpr_a: assert property (
      is_fs_to_fpr |=> fpr_we_out && fpr_data_out[31:0] == $past(float_status_ctrl_reg_out) &&
         fpr_idx_out == $past(dest_fpr) && !gpr_we_out)
      else $error("Status to float move is wrong.");

   fs_fpr_record_a: assert property (
      is_fs_to_fpr && !reg_wr_in |=> $stable(float_status_ctrl_reg_out) &&
         cond_reg_out[27:24] == ($past(record_flag) ?
            $past(float_status_ctrl_reg_out[31:28]) : $past(cond_reg_out[27:24])))
      else $error("Status to float move changed status or field one wrongly.");

   // Only the four consumed exception bits may change; status must not move at all.
   exc_rest_a: assert property (
      is_exc_to_cond && !reg_wr_in |=> fixed_exception_reg_out[27:0] ==
         $past(fixed_exception_reg_out[27:0]) && $stable(float_status_ctrl_reg_out))
      else $error("Exception to condition copy disturbed other bits.");

   // A word outside the six operations must only raise the flag, never a write strobe.
   illegal_flag_a: assert property (
      instr_valid_in && !(is_insert || is_field_copy || is_fs_to_cond || is_exc_to_cond ||
         is_cond_to_gpr || is_fs_to_fpr) |=> illegal_out && !gpr_we_out && !fpr_we_out)
      else $error("Unknown instruction word was not flagged.");

   // Condition-only moves write no register file and are never flagged.
   cond_quiet_a: assert property (
      is_field_copy || is_fs_to_cond || is_exc_to_cond |=> !illegal_out && !gpr_we_out &&
         !fpr_we_out)
      else $error("Condition move raised a stray strobe.");

endmodule // cr_mask_move_unit

// [test/cr_mask_move_unit_tb.sv]
// Purpose: Self-checking bench for the mask insert and condition move unit.
// Assumes: One-cycle result latency and the register port offsets of the package.
// Notes: A bench model tracks the three architected registers and predicts every result.
`timescale 1ns/1ps

module testbench;
   import cr_move_pkg::*;

   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic instr_valid_in = 1'b0;
   logic [31:0] instr_in = 32'h0;
   logic [31:0] source_gpr_in = 32'h0;
   logic [31:0] insert_target_gpr_in = 32'h0;
   logic [31:0] mask_gpr_in = 32'h0;
   logic [1:0] reg_addr_in = 2'h0;
   logic [31:0] reg_wdata_in = 32'h0;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [31:0] reg_rdata_out, gpr_data_out, cond_reg_out;
   logic [31:0] fixed_exception_reg_out, float_status_ctrl_reg_out;
   logic [4:0] gpr_idx_out, fpr_idx_out;
   logic [63:0] fpr_data_out;
   logic gpr_we_out, fpr_we_out, illegal_out;
   // Model state, expected strobes and bookkeeping.
   logic [31:0] cr, exc, fs, seed, e_gd, w, src, tgt, msk;
   logic [63:0] e_fd;
   logic [4:0] e_gi, e_fi;
   logic e_g, e_f, e_ill, rd_ill;
   int err_total = 0;
   int total_checks = 0;
   localparam logic [31:0] FS_KEEP = ~FS_RESERVED_MASK;

   cr_mask_move_unit DUT (
      .mclk_in(mclk_in), .rst_n_in(rst_n_in), .instr_valid_in(instr_valid_in),
      .instr_in(instr_in), .source_gpr_in(source_gpr_in),
      .insert_target_gpr_in(insert_target_gpr_in), .mask_gpr_in(mask_gpr_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .gpr_we_out(gpr_we_out),
      .gpr_idx_out(gpr_idx_out), .gpr_data_out(gpr_data_out), .fpr_we_out(fpr_we_out),
      .fpr_idx_out(fpr_idx_out), .fpr_data_out(fpr_data_out), .illegal_out(illegal_out),
      .cond_reg_out(cond_reg_out), .fixed_exception_reg_out(fixed_exception_reg_out),
      .float_status_ctrl_reg_out(float_status_ctrl_reg_out));

   // Core clock at 40 MHz.
   initial begin
      forever #12.5 mclk_in = ~mclk_in;
   end

   // Xorshift generator; a fixed start keeps every run identical.
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Compares one value and counts it.
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // One register write; the model follows unless the offset is read-only.
   task automatic reg_write(input logic [1:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge mclk_in);
      reg_wr_in <= 1'b0;
      if (a == ADDR_COND) cr = d;
      else if (a == ADDR_FIXED_EXC) exc = d;
      else if (a == ADDR_FLOAT_STATUS) fs = d;
   endtask

   // One register read; data stand only in the cycle after the strobe.
   task automatic reg_read(input logic [1:0] a, input logic [31:0] exp, input logic [31:0] m);
      @(posedge mclk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge mclk_in);
      reg_rd_in <= 1'b0;
      #1 chk(reg_rdata_out & m, exp & m);
      @(posedge mclk_in);
      #1 chk(reg_rdata_out, 32'h0);
   endtask

   // Checks the outputs produced by the instruction taken at the last edge.
   task automatic check_step();
      chk(gpr_we_out, e_g);
      chk(fpr_we_out, e_f);
      chk(illegal_out, e_ill);
      if (e_g) chk({gpr_idx_out, gpr_data_out}, {e_gi, e_gd});
      if (e_f) chk({fpr_idx_out, fpr_data_out & {32'hFFFF_FFFF, FS_KEEP}}, {e_fi, e_fd});
      chk(cond_reg_out, cr);
      chk(fixed_exception_reg_out, exc);
      chk(float_status_ctrl_reg_out & FS_KEEP, fs & FS_KEEP);
   endtask

   // Model of one instruction, reading the state left by the previous one.
   task automatic model(input logic [31:0] i);
      logic [2:0] dfld, sfld;
      logic [31:0] r;
      logic [3:0] clr;
      dfld = i[25:23];
      sfld = i[20:18];
      e_g = 1'b0;
      e_f = 1'b0;
      e_ill = 1'b0;
      if (i[31:26] == OP_FIXED && i[10:1] == XO_MASK_INSERT) begin
         r = (src & msk) | (tgt & ~msk);
         {e_g, e_gi, e_gd} = {1'b1, i[20:16], r};
         if (i[0]) cr[31:28] = {$signed(r) < 0, $signed(r) > 0, r == 32'h0, exc[31]};
      end else if (i[31:26] == OP_BRANCH && i[10:1] == XO_FIELD_COPY) begin
         cr[31-4*dfld -: 4] = cr[31-4*sfld -: 4];
      end else if (i[31:26] == OP_FLOAT && i[10:1] == XO_FS_TO_COND) begin
         r = fs & FS_KEEP;
         cr[31-4*dfld -: 4] = r[31-4*sfld -: 4];
         clr = (sfld == 3'h0) ? FS_CLR_0 : (sfld == 3'h1) ? FS_CLR_1 :
               (sfld == 3'h2) ? FS_CLR_2 : (sfld == 3'h3) ? FS_CLR_3 : NIBBLE_ZERO;
         fs[31-4*sfld -: 4] = fs[31-4*sfld -: 4] & ~clr;
      end else if (i[31:26] == OP_FIXED && i[10:1] == XO_EXC_TO_COND) begin
         cr[31-4*dfld -: 4] = exc[31:28];
         exc[31:28] = NIBBLE_ZERO;
      end else if (i[31:26] == OP_FIXED && i[10:1] == XO_COND_TO_GPR) begin
         {e_g, e_gi, e_gd} = {1'b1, i[25:21], cr};
      end else if (i[31:26] == OP_FLOAT && i[10:1] == XO_FS_TO_FPR) begin
         {e_f, e_fi, e_fd} = {1'b1, i[25:21], FPR_UPPER_FILL, fs & FS_KEEP};
         if (i[0]) cr[27:24] = fs[31:28];
      end else begin
         e_ill = 1'b1;
      end
   endtask

   // Cuts a hung run short.
   initial begin
      #250000;
      err_total++;
      tally_and_finish();
   end

   // Main sequence: reset, then rounds of register writes, bursts and read-back.
   initial begin
      logic [9:0] xo_tab [7];
      logic [5:0] op_tab [7];
      int kind;
      xo_tab = '{XO_MASK_INSERT, XO_FIELD_COPY, XO_FS_TO_COND, XO_EXC_TO_COND,
                 XO_COND_TO_GPR, XO_FS_TO_FPR, 10'h037};
      op_tab = '{OP_FIXED, OP_BRANCH, OP_FLOAT, OP_FIXED, OP_FIXED, OP_FLOAT, OP_FIXED};
      seed = 32'h0000_004B;
      {e_g, e_f, e_ill} = 3'h0;
      repeat (8) @(posedge mclk_in);
      chk({cond_reg_out, fixed_exception_reg_out}, {COND_RESET, FIXED_EXC_RESET});
      chk(float_status_ctrl_reg_out, FLOAT_STATUS_RESET);
      rst_n_in <= 1'b1;
      {cr, exc, fs} = {COND_RESET, FIXED_EXC_RESET, FLOAT_STATUS_RESET};
      for (int n = 0; n < 60; n++) begin
         reg_write(ADDR_COND, rnd());
         reg_write(ADDR_FIXED_EXC, rnd());
         reg_write(ADDR_FLOAT_STATUS, rnd());
         reg_write(ADDR_STATUS, rnd());
         for (int k = 0; k <= 9; k++) begin
            @(posedge mclk_in);
            if (k < 8) begin
               kind = int'(rnd() % 7);
               w = rnd();
               w[31:26] = op_tab[kind];
               w[10:1] = xo_tab[kind];
               {src, tgt, msk} = {rnd(), rnd(), rnd()};
               instr_valid_in <= 1'b1;
               instr_in <= w;
               {source_gpr_in, insert_target_gpr_in, mask_gpr_in} <= {src, tgt, msk};
            end else begin
               // The status read is taken while the last word's flag still stands.
               instr_valid_in <= 1'b0;
               reg_addr_in <= ADDR_STATUS;
               reg_rd_in <= (k == 8);
            end
            #1 check_step();
            if (k == 9) chk(reg_rdata_out, 32'(rd_ill));
            rd_ill = e_ill;
            {e_g, e_f, e_ill} = 3'h0;
            if (k < 8) model(w);
         end
         reg_read(ADDR_COND, cr, 32'hFFFF_FFFF);
         reg_read(ADDR_FIXED_EXC, exc, 32'hFFFF_FFFF);
         reg_read(ADDR_FLOAT_STATUS, fs, FS_KEEP);
         reg_read(ADDR_STATUS, 32'h0, 32'hFFFF_FFFF);
      end
      tally_and_finish();
   end
endmodule // testbench
